// ---- hw/apg_defs.vh ----
`ifndef APG_DEFS_VH
`define APG_DEFS_VH

// operand codes, one space shared by both operand sets
`define APG_OP_PLAIN      5'h00
`define APG_OP_POSTINC    5'h01
`define APG_OP_POSTDEC    5'h02
`define APG_OP_PREINC     5'h03
`define APG_OP_PREDEC     5'h04
`define APG_OP_ADD_P0     5'h05
`define APG_OP_ADD_T0     5'h06
`define APG_OP_SUB_P0     5'h07
`define APG_OP_SUB_T0     5'h08
`define APG_OP_OFS_P0     5'h09
`define APG_OP_OFS_T0     5'h0A
`define APG_OP_OFS_T1     5'h0B
`define APG_OP_ADD_T1     5'h0C
`define APG_OP_SUB_T1     5'h0D
`define APG_OP_BRADD_P0   5'h0E
`define APG_OP_BRADD_T0   5'h0F
`define APG_OP_BRSUB_P0   5'h10
`define APG_OP_BRSUB_T0   5'h11
`define APG_OP_OFS_K16    5'h12
`define APG_OP_PREADD_K16 5'h13
`define APG_OP_OFS_K3     5'h14

// access kinds
`define APG_KIND_DATA     2'h0
`define APG_KIND_IO       2'h1
`define APG_KIND_BIT      2'h2

// register classes a bit access may target
`define APG_TGT_ACC       2'h0
`define APG_TGT_AUX       2'h1
`define APG_TGT_TMP       2'h2
`define APG_TGT_NONE      2'h3

// pointer file layout
`define APG_PTR_W         23
`define APG_PTR_N         9
`define APG_PTR_COEF      4'h8
`define APG_PTR_RST       23'h000000
`define APG_LOW_W         16

`endif

// ---- hw/apg_ptr_file.v ----
`timescale 1ns/100ps
`include "apg_defs.vh"

module apg_ptr_file (
  // clock and reset
  input  wire                              clk_in,
  input  wire                              rst_in,
  // software load port
  input  wire                              load_en_in,
  input  wire                              load_full_in,
  input  wire [3:0]                        load_sel_in,
  input  wire [`APG_PTR_W-1:0]             load_data_in,
  // lane x update
  input  wire                              x_we_in,
  input  wire [3:0]                        x_sel_in,
  input  wire [`APG_PTR_W-1:0]             x_data_in,
  // lane y update
  input  wire                              y_we_in,
  input  wire [3:0]                        y_sel_in,
  input  wire [`APG_PTR_W-1:0]             y_data_in,
  // all pointers, entry i at [i*23 +: 23]
  output wire [`APG_PTR_W*`APG_PTR_N-1:0]  ptrs_out
);

  reg [`APG_PTR_W-1:0] ptr_r [0:`APG_PTR_N-1];
  integer i;

  always @(posedge clk_in) begin
    for (i = 0; i < `APG_PTR_N; i = i + 1) begin
      if (rst_in) begin
        ptr_r[i] <= `APG_PTR_RST;
      end else if (load_en_in && load_sel_in == i[3:0]) begin
        // high part only ever written together with the low part
        if (load_full_in) begin
          ptr_r[i] <= load_data_in;
        end else begin
          ptr_r[i][`APG_LOW_W-1:0] <= load_data_in[`APG_LOW_W-1:0];
        end
      end else if (x_we_in && x_sel_in == i[3:0]) begin
        ptr_r[i] <= x_data_in;
      end else if (y_we_in && y_sel_in == i[3:0]) begin
        ptr_r[i] <= y_data_in;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `APG_PTR_N; g = g + 1) begin : flat
      assign ptrs_out[g*`APG_PTR_W +: `APG_PTR_W] = ptr_r[g];
    end
  endgenerate

endmodule

// ---- hw/apg_agen.v ----
`timescale 1ns/100ps
`include "apg_defs.vh"

module apg_agen (
  // clock and reset
  input  wire        CLK_IN,
  input  wire        RST_IN,
  // status and circular configuration
  input  wire        POINTER_MODE_SELECT_IN,
  input  wire        LEGACY_COMPAT_BIT_IN,
  input  wire [8:0]  CIRC_EN_IN,
  input  wire [15:0] BUFFER_START_PAIR01_IN,
  input  wire [15:0] BUFFER_START_PAIR23_IN,
  input  wire [15:0] BUFFER_START_PAIR45_IN,
  input  wire [15:0] BUFFER_START_PAIR67_IN,
  input  wire [15:0] BUFFER_START_COEF_IN,
  input  wire [15:0] BUF_SIZE_03_IN,
  input  wire [15:0] BUF_SIZE_47_IN,
  input  wire [15:0] BUF_SIZE_COEF_IN,
  // index registers
  input  wire [15:0] TEMP_INDEX_ZERO_IN,
  input  wire [15:0] TEMP_INDEX_ONE_IN,
  // operand lane x
  input  wire        X_VALID_IN,
  input  wire [3:0]  X_SEL_IN,
  input  wire [4:0]  X_OP_IN,
  input  wire [1:0]  X_KIND_IN,
  input  wire        X_WIDE_IN,
  input  wire [1:0]  X_BIT_TGT_IN,
  input  wire [15:0] X_K16_IN,
  input  wire [2:0]  X_K3_IN,
  // operand lane y, dual access
  input  wire        Y_VALID_IN,
  input  wire [2:0]  Y_SEL_IN,
  input  wire [4:0]  Y_OP_IN,
  input  wire        Y_WIDE_IN,
  // pointer load
  input  wire        LOAD_LOW_IN,
  input  wire        LOAD_EXT_IN,
  input  wire [3:0]  LOAD_SEL_IN,
  input  wire [22:0] LOAD_DATA_IN,
  // pointer readback
  input  wire [3:0]  RD_SEL_IN,
  // addresses
  output wire [22:0] X_ADDR_OUT,
  output wire        X_ADDR_VALID_OUT,
  output wire [22:0] Y_ADDR_OUT,
  output wire        Y_ADDR_VALID_OUT,
  // status
  output reg         X_REJECT_OUT,
  output reg         Y_REJECT_OUT,
  output reg         UPDATE_DONE_OUT,
  output reg  [22:0] RD_DATA_OUT
);

  // reverse the bit order of a 16-bit word
  function [15:0] apg_rev16;
    input [15:0] v;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        apg_rev16[k] = v[15-k];
      end
    end
  endfunction
  // step a buffer index inside [0, size); step magnitude below size
  function [15:0] apg_circ;
    input [15:0] idx;
    input        sub;
    input [15:0] d;
    input [15:0] size;
    reg   [17:0] dx;
    reg   [17:0] s;
    begin
      dx = sub ? (18'h00000 - {{2{d[15]}}, d}) : {{2{d[15]}}, d};
      s = {2'h0, idx} + dx;
      if (s[17]) begin
        s = s + {2'h0, size};
      end else if (s >= {2'h0, size}) begin
        s = s - {2'h0, size};
      end
      apg_circ = s[15:0];
    end
  endfunction
  // result: {ok, update, address[22:0], new pointer[22:0]}
  function [47:0] apg_gen;
    input [4:0]  op;
    input        ctl;
    input        compat;
    input [1:0]  kind;
    input        wide;
    input [1:0]  tgt;
    input [22:0] p;
    input        circ;
    input [15:0] bsa;
    input [15:0] size;
    input [15:0] ar0;
    input [15:0] t0;
    input [15:0] t1;
    input [15:0] k16;
    input [2:0]  k3;
    reg          ok, upd, pre, brev, sub;
    reg   [15:0] idx, lo;
    reg   [22:0] dx, mp, eff, addr;
    begin
      ok   = 1'b1;
      upd  = 1'b0;
      pre  = 1'b0;
      brev = 1'b0;
      sub  = 1'b0;
      idx  = 16'h0000;
      case (op)
        `APG_OP_PLAIN: upd = 1'b0;
        `APG_OP_POSTINC: begin
          upd = 1'b1;
          idx = wide ? 16'h0002 : 16'h0001;
        end
        `APG_OP_POSTDEC: begin
          upd = 1'b1;
          sub = 1'b1;
          idx = wide ? 16'h0002 : 16'h0001;
        end
        `APG_OP_PREINC: begin
          upd = 1'b1;
          pre = 1'b1;
          idx = wide ? 16'h0002 : 16'h0001;
          ok  = ~ctl;
        end
        `APG_OP_PREDEC: begin
          upd = 1'b1;
          pre = 1'b1;
          sub = 1'b1;
          idx = wide ? 16'h0002 : 16'h0001;
          ok  = ~ctl;
        end
        `APG_OP_ADD_P0: begin
          upd = 1'b1;
          idx = ar0;
          ok  = compat;
        end
        `APG_OP_ADD_T0: begin
          upd = 1'b1;
          idx = t0;
          ok  = ~compat;
        end
        `APG_OP_SUB_P0: begin
          upd = 1'b1;
          sub = 1'b1;
          idx = ar0;
          ok  = compat;
        end
        `APG_OP_SUB_T0: begin
          upd = 1'b1;
          sub = 1'b1;
          idx = t0;
          ok  = ~compat;
        end
        `APG_OP_OFS_P0: begin
          pre = 1'b1;
          idx = ar0;
          ok  = compat;
        end
        `APG_OP_OFS_T0: begin
          pre = 1'b1;
          idx = t0;
          ok  = ~compat;
        end
        `APG_OP_OFS_T1: begin
          pre = 1'b1;
          idx = t1;
          ok  = ~ctl;
        end
        `APG_OP_ADD_T1: begin
          upd = 1'b1;
          idx = t1;
          ok  = ~ctl;
        end
        `APG_OP_SUB_T1: begin
          upd = 1'b1;
          sub = 1'b1;
          idx = t1;
          ok  = ~ctl;
        end
        `APG_OP_BRADD_P0: begin
          brev = 1'b1;
          upd  = ~circ;
          idx  = ar0;
          ok   = compat & ~ctl;
        end
        `APG_OP_BRADD_T0: begin
          brev = 1'b1;
          upd  = ~circ;
          idx  = t0;
          ok   = ~compat & ~ctl;
        end
        `APG_OP_BRSUB_P0: begin
          brev = 1'b1;
          sub  = 1'b1;
          upd  = ~circ;
          idx  = ar0;
          ok   = compat & ~ctl;
        end
        `APG_OP_BRSUB_T0: begin
          brev = 1'b1;
          sub  = 1'b1;
          upd  = ~circ;
          idx  = t0;
          ok   = ~compat & ~ctl;
        end
        `APG_OP_OFS_K16: begin
          pre = 1'b1;
          idx = k16;
          ok  = (kind != `APG_KIND_IO);
        end
        `APG_OP_PREADD_K16: begin
          upd = 1'b1;
          pre = 1'b1;
          idx = k16;
          ok  = (kind != `APG_KIND_IO);
        end
        `APG_OP_OFS_K3: begin
          pre = 1'b1;
          idx = {13'h0000, k3};
          ok  = ctl & (k3 != 3'h0);
        end
        default: ok = 1'b0;
      endcase
      // bit numbers only into accumulators, pointers, temporaries; kind 3 unused
      if ((kind == `APG_KIND_BIT && tgt == `APG_TGT_NONE) || kind == 2'h3) begin
        ok = 1'b0;
      end
      dx = {{7{idx[15]}}, idx};
      if (brev) begin
        // reverse order makes the carry run from msb toward lsb
        if (sub) begin
          lo = apg_rev16(apg_rev16(p[15:0]) - apg_rev16(idx));
        end else begin
          lo = apg_rev16(apg_rev16(p[15:0]) + apg_rev16(idx));
        end
        mp = {p[22:16], lo};
      end else if (circ) begin
        mp = {p[22:16], apg_circ(p[15:0], sub, idx, size)};
      end else begin
        mp = sub ? (p - dx) : (p + dx);
      end
      eff = pre ? mp : p;
      // io and bit kinds take the low part alone, no page and no start
      addr = {7'h00, eff[15:0]};
      if (kind == `APG_KIND_DATA) begin
        addr = circ ? {eff[22:16], eff[15:0] + bsa} : eff;
      end
      apg_gen = {ok, ok & upd, addr, upd ? mp : p};
    end
  endfunction
  // configuration laid out per pointer index, entry 8 is the coefficient
  wire [143:0] bsa_flat;
  wire [143:0] size_flat;
  wire [206:0] ptrs;
  assign bsa_flat = {BUFFER_START_COEF_IN,
                     BUFFER_START_PAIR67_IN, BUFFER_START_PAIR67_IN,
                     BUFFER_START_PAIR45_IN, BUFFER_START_PAIR45_IN,
                     BUFFER_START_PAIR23_IN, BUFFER_START_PAIR23_IN,
                     BUFFER_START_PAIR01_IN, BUFFER_START_PAIR01_IN};
  assign size_flat = {BUF_SIZE_COEF_IN,
                      BUF_SIZE_47_IN, BUF_SIZE_47_IN,
                      BUF_SIZE_47_IN, BUF_SIZE_47_IN,
                      BUF_SIZE_03_IN, BUF_SIZE_03_IN,
                      BUF_SIZE_03_IN, BUF_SIZE_03_IN};
  wire        x_sel_ok;
  wire [3:0]  x_sel;
  wire [3:0]  y_sel;
  wire [22:0] x_ptr;
  wire [22:0] y_ptr;
  wire [15:0] ar0_val;
  wire [47:0] x_res;
  wire [47:0] y_res;
  wire        x_ok;
  wire        y_ok;
  wire        x_we;
  wire        y_we;
  // selects above the coefficient entry are rejected, not aliased
  assign x_sel_ok = (X_SEL_IN <= `APG_PTR_COEF);
  assign x_sel    = x_sel_ok ? X_SEL_IN : 4'h0;
  assign y_sel    = {1'b0, Y_SEL_IN};
  assign x_ptr    = ptrs[{4'h0, x_sel} * 8'd23 +: 23];
  assign y_ptr    = ptrs[{4'h0, y_sel} * 8'd23 +: 23];
  assign ar0_val  = ptrs[15:0];
  assign x_res = apg_gen(X_OP_IN, POINTER_MODE_SELECT_IN, LEGACY_COMPAT_BIT_IN,
                         X_KIND_IN, X_WIDE_IN, X_BIT_TGT_IN, x_ptr,
                         CIRC_EN_IN[x_sel],
                         bsa_flat[{x_sel, 4'h0} +: 16],
                         size_flat[{x_sel, 4'h0} +: 16],
                         ar0_val, TEMP_INDEX_ZERO_IN, TEMP_INDEX_ONE_IN,
                         X_K16_IN, X_K3_IN);
  // dual operands: same generation, fixed DSP set, data space only
  assign y_res = apg_gen(Y_OP_IN, 1'b0, LEGACY_COMPAT_BIT_IN,
                         `APG_KIND_DATA, Y_WIDE_IN, `APG_TGT_ACC, y_ptr,
                         CIRC_EN_IN[y_sel],
                         bsa_flat[{y_sel, 4'h0} +: 16],
                         size_flat[{y_sel, 4'h0} +: 16],
                         ar0_val, TEMP_INDEX_ZERO_IN, TEMP_INDEX_ONE_IN,
                         16'h0000, 3'h0);
  assign x_ok = X_VALID_IN & x_sel_ok & x_res[47];
  assign y_ok = Y_VALID_IN & y_res[47] & (Y_OP_IN < `APG_OP_OFS_K16);
  assign x_we = x_ok & x_res[46];
  assign y_we = y_ok & y_res[46];
  // combinational so the access can start in the decode cycle
  assign X_ADDR_OUT       = x_res[45:23];
  assign X_ADDR_VALID_OUT = x_ok;
  assign Y_ADDR_OUT       = y_res[45:23];
  assign Y_ADDR_VALID_OUT = y_ok;
  apg_ptr_file u_ptrs (
    .clk_in       (CLK_IN),
    .rst_in       (RST_IN),
    .load_en_in   (LOAD_LOW_IN | LOAD_EXT_IN),
    .load_full_in (LOAD_EXT_IN),
    .load_sel_in  (LOAD_SEL_IN),
    .load_data_in (LOAD_DATA_IN),
    .x_we_in      (x_we),
    .x_sel_in     (x_sel),
    .x_data_in    (x_res[22:0]),
    .y_we_in      (y_we),
    .y_sel_in     (y_sel),
    .y_data_in    (y_res[22:0]),
    .ptrs_out     (ptrs)
  );

  wire [3:0] rd_sel;
  assign rd_sel = (RD_SEL_IN <= `APG_PTR_COEF) ? RD_SEL_IN : 4'h0;
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      X_REJECT_OUT    <= 1'b0;
      Y_REJECT_OUT    <= 1'b0;
      UPDATE_DONE_OUT <= 1'b0;
      RD_DATA_OUT     <= `APG_PTR_RST;
    end else begin
      X_REJECT_OUT    <= X_VALID_IN & ~x_ok;
      Y_REJECT_OUT    <= Y_VALID_IN & ~y_ok;
      UPDATE_DONE_OUT <= x_we | y_we;
      RD_DATA_OUT     <= ptrs[{4'h0, rd_sel} * 8'd23 +: 23];
    end
  end
endmodule

// ---- bench/apg_agen_properties.sv ----
`timescale 1ns/100ps
module apg_agen_properties (
  // clock and reset
  input wire        CLK_IN,
  input wire        RST_IN,
  // mode and operand inputs
  input wire        POINTER_MODE_SELECT_IN,
  input wire        LEGACY_COMPAT_BIT_IN,
  input wire [8:0]  CIRC_EN_IN,
  input wire        X_VALID_IN,
  input wire [3:0]  X_SEL_IN,
  input wire [4:0]  X_OP_IN,
  input wire [1:0]  X_KIND_IN,
  input wire        X_WIDE_IN,
  input wire        Y_VALID_IN,
  input wire        LOAD_LOW_IN,
  input wire        LOAD_EXT_IN,
  input wire [3:0]  LOAD_SEL_IN,
  input wire [22:0] LOAD_DATA_IN,
  input wire [3:0]  RD_SEL_IN,
  // design outputs
  input wire [22:0] X_ADDR_OUT,
  input wire        X_ADDR_VALID_OUT,
  input wire        X_REJECT_OUT,
  input wire        UPDATE_DONE_OUT,
  input wire [22:0] RD_DATA_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // a load beats a lane update to the same pointer, so step checks skip load cycles
  wire ld = LOAD_LOW_IN | LOAD_EXT_IN;

  chk_refuse_pulse: assert property (
    X_VALID_IN && !X_ADDR_VALID_OUT |=> X_REJECT_OUT)
    else $error("refused operand without reject pulse");
  chk_ptr_zero_compat: assert property (
    X_VALID_IN && !LEGACY_COMPAT_BIT_IN && X_OP_IN inside {5'h05, 5'h07, 5'h09, 5'h0E, 5'h10}
    |-> !X_ADDR_VALID_OUT)
    else $error("pointer-zero index form taken with compat clear");
  chk_temp_zero_compat: assert property (
    X_VALID_IN && LEGACY_COMPAT_BIT_IN && X_OP_IN inside {5'h06, 5'h08, 5'h0A, 5'h0F, 5'h11}
    |-> !X_ADDR_VALID_OUT)
    else $error("temp-zero index form taken with compat set");
  chk_mode_set: assert property (
    X_VALID_IN && ((POINTER_MODE_SELECT_IN && X_OP_IN inside {5'h03, 5'h04})
    || (!POINTER_MODE_SELECT_IN && X_OP_IN == 5'h14)) |-> !X_ADDR_VALID_OUT)
    else $error("operand outside the selected operand set taken");
  chk_io_no_page: assert property (
    X_ADDR_VALID_OUT && X_KIND_IN == 2'h1 |-> X_ADDR_OUT[22:16] == 7'h00)
    else $error("io address carries page bits");
  chk_post_step: assert property (
    (X_ADDR_VALID_OUT && X_OP_IN == 5'h01 && X_KIND_IN == 2'h0 && !CIRC_EN_IN[X_SEL_IN] && !ld)
    ##1 (X_ADDR_VALID_OUT && X_OP_IN == 5'h00 && X_KIND_IN == 2'h0
    && !CIRC_EN_IN[X_SEL_IN] && X_SEL_IN == $past(X_SEL_IN))
    |-> X_ADDR_OUT == $past(X_ADDR_OUT) + ($past(X_WIDE_IN) ? 23'h000002 : 23'h000001))
    else $error("post increment step wrong");
  chk_commit_done: assert property (
    X_ADDR_VALID_OUT && X_OP_IN inside {5'h01, 5'h02, 5'h03, 5'h04} && !ld
    |=> UPDATE_DONE_OUT)
    else $error("pointer step not committed at next edge");
  chk_offset_keeps: assert property (
    X_ADDR_VALID_OUT && X_OP_IN inside {5'h00, 5'h09, 5'h0A, 5'h0B} && !Y_VALID_IN && !ld
    |=> !UPDATE_DONE_OUT)
    else $error("offset form modified a pointer");
  chk_ext_load: assert property (
    (LOAD_EXT_IN && LOAD_SEL_IN <= 4'h8) ##1 (RD_SEL_IN == $past(LOAD_SEL_IN))
    |=> RD_DATA_OUT == $past(LOAD_DATA_IN, 2))
    else $error("full pointer load not read back");
endmodule

bind apg_agen apg_agen_properties u_props (
  .CLK_IN, .RST_IN, .POINTER_MODE_SELECT_IN, .LEGACY_COMPAT_BIT_IN, .CIRC_EN_IN,
  .X_VALID_IN, .X_SEL_IN, .X_OP_IN, .X_KIND_IN, .X_WIDE_IN, .Y_VALID_IN,
  .LOAD_LOW_IN, .LOAD_EXT_IN, .LOAD_SEL_IN, .LOAD_DATA_IN, .RD_SEL_IN,
  .X_ADDR_OUT, .X_ADDR_VALID_OUT, .X_REJECT_OUT, .UPDATE_DONE_OUT, .RD_DATA_OUT
);

// ---- bench/apg_mem_unit.sv ----
`timescale 1ns/100ps
module apg_mem_unit (
  // clock
  input  wire        clk_in,
  // address ports
  input  wire        x_req_in,
  input  wire [22:0] x_addr_in,
  input  wire        y_req_in,
  input  wire [22:0] y_addr_in,
  // last address taken
  output reg  [22:0] x_last_out,
  output reg  [22:0] y_last_out
);
  // takes an address only at the edge ending its cycle, like a real port
  always @(posedge clk_in) begin
    if (x_req_in) begin
      x_last_out <= x_addr_in;
    end
    if (y_req_in) begin
      y_last_out <= y_addr_in;
    end
  end
endmodule

// ---- bench/test_apg_agen.sv ----
`timescale 1ns/100ps
module test_apg_agen;
  reg         clk;
  reg         rst;
  reg         mode;
  reg         compat;
  reg  [8:0]  circ;
  reg  [15:0] bsa;
  reg  [15:0] bsz;
  reg  [15:0] t0;
  reg  [15:0] t1;
  reg         xv;
  reg  [3:0]  xs;
  reg  [4:0]  xo;
  reg  [1:0]  xk;
  reg         xw;
  reg  [1:0]  xt;
  reg         yv;
  reg  [2:0]  ys;
  reg  [4:0]  yo;
  reg         ldl;
  reg         lde;
  reg  [3:0]  lsel;
  reg  [22:0] ldat;
  wire [22:0] xa;
  wire        xav;
  wire [22:0] ya;
  wire        yav;
  wire        xrej;
  wire        yrej;
  wire        upd;
  wire [22:0] rdd;
  wire [22:0] xlast;
  wire [22:0] ylast;
  integer     err_total;
  integer     checks;

  apg_agen dut (
    .CLK_IN(clk), .RST_IN(rst), .POINTER_MODE_SELECT_IN(mode), .LEGACY_COMPAT_BIT_IN(compat),
    .CIRC_EN_IN(circ), .BUFFER_START_PAIR01_IN(bsa), .BUFFER_START_PAIR23_IN(bsa),
    .BUFFER_START_PAIR45_IN(bsa), .BUFFER_START_PAIR67_IN(bsa), .BUFFER_START_COEF_IN(bsa),
    .BUF_SIZE_03_IN(bsz), .BUF_SIZE_47_IN(bsz), .BUF_SIZE_COEF_IN(bsz),
    .TEMP_INDEX_ZERO_IN(t0), .TEMP_INDEX_ONE_IN(t1), .X_VALID_IN(xv), .X_SEL_IN(xs),
    .X_OP_IN(xo), .X_KIND_IN(xk), .X_WIDE_IN(xw), .X_BIT_TGT_IN(xt), .X_K16_IN(t1),
    .X_K3_IN(3'h3), .Y_VALID_IN(yv), .Y_SEL_IN(ys), .Y_OP_IN(yo), .Y_WIDE_IN(xw),
    .LOAD_LOW_IN(ldl), .LOAD_EXT_IN(lde), .LOAD_SEL_IN(lsel), .LOAD_DATA_IN(ldat),
    .RD_SEL_IN(lsel), .X_ADDR_OUT(xa), .X_ADDR_VALID_OUT(xav), .Y_ADDR_OUT(ya),
    .Y_ADDR_VALID_OUT(yav), .X_REJECT_OUT(xrej), .Y_REJECT_OUT(yrej), .UPDATE_DONE_OUT(upd),
    .RD_DATA_OUT(rdd));

  apg_mem_unit mem (.clk_in(clk), .x_req_in(xav), .x_addr_in(xa), .y_req_in(yav),
    .y_addr_in(ya), .x_last_out(xlast), .y_last_out(ylast));

  always #5 clk = ~clk;

  task chk(input string n, input [22:0] e, input [22:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("mismatch %s expected %h seen %h", n, e, g);
      end
    end
  endtask

  // operand held from one falling edge to the next; refusals wait for the pulse
  task xop(input [3:0] s, input [4:0] o, input [1:0] k, input w, input ev, input [22:0] ea);
    begin
      @(negedge clk);
      xs = s;
      xo = o;
      xk = k;
      xw = w;
      xv = 1'b1;
      #1;
      chk("addr valid", {22'h0, ev}, {22'h0, xav});
      if (ev) begin
        chk("addr", ea, xa);
      end else begin
        // pulse stands for the cycle after the refused edge
        @(negedge clk);
        xv = 1'b0;
        chk("reject", 23'h000001, {22'h0, xrej});
      end
    end
  endtask

  task load(input [3:0] s, input [22:0] d, input e);
    begin
      @(negedge clk);
      xv = 1'b0;
      lsel = s;
      ldat = d;
      ldl = ~e;
      lde = e;
      @(negedge clk);
      ldl = 1'b0;
      lde = 1'b0;
    end
  endtask

  task t_step;
    begin
      load(4'h2, 23'h00FFFF, 1'b1);
      xop(4'h2, 5'h01, 2'h0, 1'b0, 1'b1, 23'h00FFFF);
      xop(4'h2, 5'h00, 2'h0, 1'b0, 1'b1, 23'h010000);
      xop(4'h2, 5'h01, 2'h0, 1'b1, 1'b1, 23'h010000);
      xop(4'h2, 5'h02, 2'h0, 1'b1, 1'b1, 23'h010002);
      xop(4'h2, 5'h03, 2'h0, 1'b0, 1'b1, 23'h010001);
      xop(4'h2, 5'h04, 2'h0, 1'b1, 1'b1, 23'h00FFFF);
      xop(4'h2, 5'h00, 2'h0, 1'b0, 1'b1, 23'h00FFFF);
      load(4'h2, 23'h7FFFFF, 1'b1);
      xop(4'h2, 5'h01, 2'h0, 1'b0, 1'b1, 23'h7FFFFF);
      xop(4'h2, 5'h00, 2'h0, 1'b0, 1'b1, 23'h000000);
      $display("test step done");
    end
  endtask

  task t_kinds;
    begin
      load(4'h2, 23'h050000, 1'b1);
      load(4'h2, 23'h7F1234, 1'b0);
      @(negedge clk);
      chk("readback", 23'h051234, rdd);
      xop(4'h2, 5'h00, 2'h0, 1'b0, 1'b1, 23'h051234);
      xop(4'h2, 5'h00, 2'h1, 1'b0, 1'b1, 23'h001234);
      xop(4'h2, 5'h00, 2'h2, 1'b0, 1'b1, 23'h001234);
      xt = 2'h3;
      xop(4'h2, 5'h00, 2'h2, 1'b0, 1'b0, 23'h000000);
      xt = 2'h0;
      t1 = 16'h0010;
      xop(4'h2, 5'h12, 2'h0, 1'b0, 1'b1, 23'h051244);
      xop(4'h2, 5'h12, 2'h1, 1'b0, 1'b0, 23'h000000);
      xop(4'h2, 5'h13, 2'h0, 1'b0, 1'b1, 23'h051244);
      xop(4'h2, 5'h00, 2'h0, 1'b0, 1'b1, 23'h051244);
      load(4'h8, 23'h0A0100, 1'b1);
      xop(4'h8, 5'h00, 2'h0, 1'b0, 1'b1, 23'h0A0100);
      @(negedge clk);
      chk("memory unit", 23'h0A0100, xlast);
      $display("test kinds done");
    end
  endtask

  task t_index;
    begin
      t0 = 16'hFFFE;
      t1 = 16'h0003;
      load(4'h0, 23'h000010, 1'b1);
      load(4'h3, 23'h000100, 1'b1);
      xop(4'h3, 5'h0A, 2'h0, 1'b0, 1'b1, 23'h0000FE);
      xop(4'h3, 5'h06, 2'h0, 1'b0, 1'b1, 23'h000100);
      xop(4'h3, 5'h08, 2'h0, 1'b0, 1'b1, 23'h0000FE);
      xop(4'h3, 5'h0B, 2'h0, 1'b0, 1'b1, 23'h000103);
      xop(4'h3, 5'h0C, 2'h0, 1'b0, 1'b1, 23'h000100);
      xop(4'h3, 5'h0D, 2'h0, 1'b0, 1'b1, 23'h000103);
      xop(4'h3, 5'h05, 2'h0, 1'b0, 1'b0, 23'h000000);
      compat = 1'b1;
      xop(4'h3, 5'h09, 2'h0, 1'b0, 1'b1, 23'h000110);
      xop(4'h3, 5'h07, 2'h0, 1'b0, 1'b1, 23'h000100);
      xop(4'h3, 5'h05, 2'h0, 1'b0, 1'b1, 23'h0000F0);
      xop(4'h3, 5'h0A, 2'h0, 1'b0, 1'b0, 23'h000000);
      mode = 1'b1;
      xop(4'h3, 5'h03, 2'h0, 1'b0, 1'b0, 23'h000000);
      xop(4'h3, 5'h14, 2'h0, 1'b0, 1'b1, 23'h000103);
      mode = 1'b0;
      compat = 1'b0;
      xop(4'h3, 5'h14, 2'h0, 1'b0, 1'b0, 23'h000000);
      $display("test index done");
    end
  endtask

  task t_circ;
    begin
      circ = 9'h010;
      bsa = 16'h1000;
      bsz = 16'h0010;
      load(4'h4, 23'h20000F, 1'b1);
      xop(4'h4, 5'h01, 2'h0, 1'b0, 1'b1, 23'h20100F);
      xop(4'h4, 5'h0F, 2'h0, 1'b0, 1'b1, 23'h201000);
      xop(4'h4, 5'h00, 2'h0, 1'b0, 1'b1, 23'h201000);
      circ = 9'h000;
      t0 = 16'h0008;
      load(4'h3, 23'h000008, 1'b1);
      xop(4'h3, 5'h0F, 2'h0, 1'b0, 1'b1, 23'h000008);
      xop(4'h3, 5'h11, 2'h0, 1'b0, 1'b1, 23'h000004);
      xop(4'h3, 5'h00, 2'h0, 1'b0, 1'b1, 23'h000008);
      compat = 1'b1;
      xop(4'h3, 5'h0E, 2'h0, 1'b0, 1'b1, 23'h000008);
      xop(4'h3, 5'h10, 2'h0, 1'b0, 1'b1, 23'h000018);
      xop(4'h3, 5'h00, 2'h0, 1'b0, 1'b1, 23'h000008);
      compat = 1'b0;
      $display("test circ done");
    end
  endtask

  task t_dual;
    begin
      load(4'h5, 23'h030010, 1'b1);
      @(negedge clk);
      xw = 1'b1;
      ys = 3'h5;
      yo = 5'h01;
      yv = 1'b1;
      #1;
      chk("y addr", 23'h030010, ya);
      chk("y valid", 23'h000001, {22'h0, yav});
      @(negedge clk);
      yo = 5'h12;
      #1;
      chk("y step", 23'h030012, ya);
      chk("y memory", 23'h030010, ylast);
      chk("update done", 23'h000001, {22'h0, upd});
      chk("y refused", 23'h000000, {22'h0, yav});
      @(negedge clk);
      yv = 1'b0;
      chk("y reject", 23'h000001, {22'h0, yrej});
      $display("test dual done");
    end
  endtask

  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask

  initial begin
    #100000;
    err_total = err_total + 1;
    final_report;
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {mode, compat, circ, bsa, bsz, t0, t1, xv, xs, xo, xk, xw} = 0;
    {yv, ys, yo, ldl, lde, lsel, ldat, xt} = 0;
    err_total = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_step;
    t_kinds;
    t_index;
    t_circ;
    t_dual;
    final_report;
  end
endmodule
